// ---- io_seq_pkg.sv ----
// package of constants, states and carriers for the io channel command sequencer
package io_seq_pkg;
  localparam int CLK_MHZ = 40;
  localparam logic [3:0] OP_STATUS = 4'h1;
  localparam logic [3:0] OP_INTCTL = 4'h2;
  localparam logic [3:0] OP_START = 4'h3;
  localparam logic [1:0] DIR_WRITE = 2'h1;
  localparam logic [1:0] DIR_READ = 2'h2;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam int FLAG_CHAIN = 7;
  localparam int INT_EN_BIT = 0;
  localparam int INT_ACTIVE_BIT = 1;
  localparam int MEM_AW = 4;
  localparam logic [7:0] STAT_IDLE = 8'h00;
  localparam logic [7:0] STAT_BUSY = 8'h80;
  localparam logic [2:0] SLOT_FLAGS = 3'h0;
  localparam logic [2:0] SLOT_COUNT = 3'h1;
  localparam logic [2:0] SLOT_ADDR = 3'h2;
  localparam logic [2:0] SLOT_CMDADR = 3'h3;

  // incoming bus request to the sequencer
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] dev;
    logic [31:0] data;
  } bus_req_s;

  // command doubleword fields after decode
  typedef struct packed {
    logic [1:0] dir;
    logic [7:0] flags;
    logic [15:0] count;
    logic [31:0] addr;
  } cmd_s;

  typedef enum logic [9:0] {
    ST_IDLE = 10'b00_0000_0001,
    ST_STATUS = 10'b00_0000_0010,
    ST_CMD0_REQ = 10'b00_0000_0100,
    ST_CMD0_WAIT = 10'b00_0000_1000,
    ST_CMD1_REQ = 10'b00_0001_0000,
    ST_CMD1_WAIT = 10'b00_0010_0000,
    ST_DISPATCH = 10'b00_0100_0000,
    ST_MEM_REQ = 10'b00_1000_0000,
    ST_MEM_WAIT = 10'b01_0000_0000,
    ST_ADVANCE = 10'b10_0000_0000
  } seq_state_e;
endpackage

// ---- cmd_store.sv ----
// small register memory holding the live command fields, registered read
`timescale 1ns/1ps
module cmd_store
  import io_seq_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic arst_n, // async reset, active low
  input wire logic wr_en, // write strobe
  input wire logic [2:0] wr_slot, // write slot
  input wire logic [31:0] wr_data, // write data
  input wire logic [2:0] rd_slot, // read slot
  output logic [31:0] rd_data // registered read data
);
  logic [31:0] mem [0:7];

  // slots cleared on reset so chained reads never see garbage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 8; i++) begin
        mem[i] <= 32'h0000_0000;
      end
      rd_data <= 32'h0000_0000;
    end else begin
      if (wr_en) begin
        mem[wr_slot] <= wr_data;
      end
      rd_data <= mem[rd_slot];
    end
  end
endmodule

// ---- io_channel_command_sequencer.sv ----
// top of the io channel command sequencer: bus side, command fetch, data mover
`timescale 1ns/1ps
module io_channel_command_sequencer
  import io_seq_pkg::*;
(
  input wire logic mclk, // 40 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic req_valid, // incoming bus transfer present
  input wire bus_req_s req, // incoming transfer contents
  output logic req_ack, // acknowledge, combinational
  output logic in_clear, // input logic cleared pulse
  output logic stat_valid, // outgoing status transfer pulse
  output logic [31:0] stat_data, // status word
  output logic mem_rd_req, // memory read request pulse
  output logic mem_wr_req, // memory write request pulse
  output logic [31:0] mem_addr, // memory address
  output logic [31:0] mem_wdata, // memory write data
  input wire logic mem_ret_valid, // memory data return
  input wire logic [31:0] mem_ret_data, // right-justified return data
  output logic service_irq, // service interrupt level
  output logic [31:0] areg_out, // A register file to device
  output logic [31:0] breg_out, // B register file to device
  output logic [7:0] level_order, // steady orders
  output logic [7:0] pulse_order, // one-cycle orders
  output logic [3:0] dev_sel, // selected device
  input wire logic [31:0] ext_in, // device external inputs
  input wire logic dev_data_valid, // device offers read data
  input wire logic [3:0] test_in, // device test inputs
  output logic dev_clk, // clock to device
  output logic dev_rst_n // reset to device, active low
);
  seq_state_e state, next_state;
  cmd_s cmd;
  logic [31:0] cmd_addr;
  logic [1:0] int_ctl;
  logic [31:0] st_rdata;
  logic st_wr;
  logic [2:0] st_slot;
  logic [31:0] st_wdata;

  // decode of the accepted transfer
  wire logic idle = (state == ST_IDLE);
  // a status answer is not an operation, so a start may follow it at once
  wire logic free = idle || (state == ST_STATUS);
  wire logic is_status = req_valid && (req.op == OP_STATUS);
  wire logic is_intctl = req_valid && (req.op == OP_INTCTL);
  wire logic is_start = req_valid && (req.op == OP_START) && free;
  wire logic last_item = (cmd.count == COUNT_ONE);
  wire logic chain = cmd.flags[FLAG_CHAIN];
  wire logic busy = !free;
  wire logic dev_step = (cmd.dir == DIR_READ) ? dev_data_valid : 1'b1;
  wire logic done_evt = (state == ST_ADVANCE) && last_item && !chain;

  // every addressed transfer is acknowledged at once, even while busy
  assign req_ack = req_valid;
  assign dev_clk = mclk;
  assign dev_rst_n = arst_n;

  // shadow copy of live command fields, read back to the device B file
  cmd_store u_store (
    .mclk(mclk),
    .arst_n(arst_n),
    .wr_en(st_wr),
    .wr_slot(st_slot),
    .wr_data(st_wdata),
    .rd_slot(SLOT_ADDR),
    .rd_data(st_rdata)
  );
  assign st_wr = (state == ST_ADVANCE);
  assign st_slot = chain ? SLOT_CMDADR : SLOT_ADDR;
  assign st_wdata = chain ? cmd_addr : cmd.addr;

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (is_status) next_state = ST_STATUS;
        else if (is_start) next_state = ST_CMD0_REQ;
      end
      ST_STATUS: begin
        if (is_start) next_state = ST_CMD0_REQ;
        else next_state = ST_IDLE;
      end
      ST_CMD0_REQ: next_state = ST_CMD0_WAIT;
      ST_CMD0_WAIT: if (mem_ret_valid) next_state = ST_CMD1_REQ;
      ST_CMD1_REQ: next_state = ST_CMD1_WAIT;
      ST_CMD1_WAIT: if (mem_ret_valid) next_state = ST_DISPATCH;
      ST_DISPATCH: begin
        if (cmd.count == COUNT_ZERO) next_state = ST_IDLE;
        else next_state = ST_MEM_REQ;
      end
      ST_MEM_REQ: if (dev_step) next_state = (cmd.dir == DIR_READ) ? ST_ADVANCE : ST_MEM_WAIT;
      ST_MEM_WAIT: if (mem_ret_valid) next_state = ST_ADVANCE;
      ST_ADVANCE: begin
        if (!last_item) next_state = ST_MEM_REQ;
        else if (chain) next_state = ST_CMD0_REQ;
        else next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) state <= ST_IDLE;
    else state <= next_state;
  end

  // command address: loaded at start, stepped after each fetched word
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_addr <= 32'h0000_0000;
    end else if (is_start) begin
      cmd_addr <= req.data;
    end else if ((state == ST_CMD0_WAIT || state == ST_CMD1_WAIT) && mem_ret_valid) begin
      cmd_addr <= cmd_addr + WORD_STEP;
    end
  end

  // command fields: word0 = address, word1 = dir/flags/count; stepped per item
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd <= '0;
    end else if (state == ST_CMD0_WAIT && mem_ret_valid) begin
      cmd.addr <= mem_ret_data;
    end else if (state == ST_CMD1_WAIT && mem_ret_valid) begin
      cmd.count <= mem_ret_data[15:0];
      cmd.flags <= mem_ret_data[23:16];
      cmd.dir <= mem_ret_data[25:24];
    end else if (state == ST_ADVANCE) begin
      cmd.count <= cmd.count - COUNT_ONE;
      cmd.addr <= cmd.addr + WORD_STEP;
    end
  end

  // memory request outputs; a device read writes the sampled inputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mem_rd_req <= 1'b0;
      mem_wr_req <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
    end else begin
      mem_rd_req <= 1'b0;
      mem_wr_req <= 1'b0;
      if (state == ST_CMD0_REQ || state == ST_CMD1_REQ) begin
        mem_rd_req <= 1'b1;
        mem_addr <= cmd_addr;
      end else if (state == ST_MEM_REQ && dev_step) begin
        mem_addr <= cmd.addr;
        if (cmd.dir == DIR_READ) begin
          mem_wr_req <= 1'b1;
          mem_wdata <= ext_in;
        end else begin
          mem_rd_req <= 1'b1;
        end
      end
    end
  end

  // device outputs: returned word goes to A file, stored data address to B file
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      areg_out <= 32'h0000_0000;
      breg_out <= 32'h0000_0000;
      level_order <= 8'h00;
      pulse_order <= 8'h00;
      dev_sel <= 4'h0;
    end else begin
      pulse_order <= 8'h00;
      breg_out <= st_rdata;
      // latched at start so later bus traffic cannot move the selection mid-operation
      if (is_start) begin
        dev_sel <= req.dev;
      end
      if (state == ST_MEM_WAIT && mem_ret_valid) begin
        areg_out <= mem_ret_data;
        pulse_order <= 8'h01;
      end
      if (state == ST_DISPATCH) begin
        level_order <= {4'h0, test_in[0], 1'b1, cmd.dir};
      end else if (idle) begin
        level_order <= 8'h00;
      end
    end
  end

  // status answer, interrupt control and service interrupt
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stat_valid <= 1'b0;
      stat_data <= 32'h0000_0000;
      int_ctl <= 2'b00;
      service_irq <= 1'b0;
      in_clear <= 1'b0;
    end else begin
      in_clear <= req_valid;
      stat_valid <= 1'b0;
      if (is_status || (req_valid && req.op == OP_START && busy)) begin
        stat_valid <= 1'b1;
        stat_data <= {busy ? STAT_BUSY : STAT_IDLE, 4'h0, test_in, cmd.count};
      end
      if (is_intctl) begin
        int_ctl <= req.data[1:0];
      end
      if (done_evt && int_ctl[INT_EN_BIT]) begin
        service_irq <= 1'b1;
      end else if (is_intctl && !req.data[INT_ACTIVE_BIT]) begin
        service_irq <= 1'b0;
      end
    end
  end

  // checks
  property p_ack;
    @(posedge mclk) disable iff (!arst_n) req_valid |-> req_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("transfer not acknowledged");
  property p_clear;
    @(posedge mclk) disable iff (!arst_n) req_valid |=> in_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("input logic not cleared");
  property p_status;
    @(posedge mclk) disable iff (!arst_n) is_status |=> stat_valid;
  endproperty
  a_status: assert property (p_status) else $error("status not returned");
  property p_start;
    @(posedge mclk) disable iff (!arst_n)
      is_start |=> ##1 (mem_rd_req && mem_addr == $past(req.data, 2));
  endproperty
  a_start: assert property (p_start) else $error("start read wrong");
  property p_second;
    @(posedge mclk) disable iff (!arst_n)
      (state == ST_CMD0_WAIT && mem_ret_valid) |=> ##1
        (mem_rd_req && mem_addr == $past(mem_addr) + WORD_STEP);
  endproperty
  a_second: assert property (p_second) else $error("second word address wrong");
  property p_count;
    @(posedge mclk) disable iff (!arst_n)
      (state == ST_ADVANCE) |=> cmd.count == $past(cmd.count) - COUNT_ONE;
  endproperty
  a_count: assert property (p_count) else $error("count not decremented");
  property p_irq;
    @(posedge mclk) disable iff (!arst_n) (done_evt && int_ctl[INT_EN_BIT]) |=> service_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("service interrupt missing");
  property p_noirq;
    @(posedge mclk) disable iff (!arst_n) ($rose(service_irq)) |-> $past(int_ctl[INT_EN_BIT]);
  endproperty
  a_noirq: assert property (p_noirq) else $error("interrupt while disabled");
  property p_busy;
    @(posedge mclk) disable iff (!arst_n) (req_valid && req.op == OP_START && busy) |=>
      (state != ST_CMD0_REQ || $past(state) == ST_ADVANCE);
  endproperty
  a_busy: assert property (p_busy) else $error("start accepted while busy");
  property p_done;
    @(posedge mclk) disable iff (!arst_n) done_evt |=> idle;
  endproperty
  a_done: assert property (p_done) else $error("no finish at zero count");
  // ==========================================================
  // data path checks
  // address of the last command word asked for, so the chain check does not
  // lean on the command address register that it is meant to police
  logic [31:0] fetch_addr;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) fetch_addr <= 32'h0000_0000;
    else if (state == ST_CMD1_WAIT && mem_rd_req) fetch_addr <= mem_addr;
  end
  property p_chain;
    @(posedge mclk) disable iff (!arst_n)
      (state == ST_ADVANCE && last_item && chain) |=> ##1
        (mem_rd_req && mem_addr == fetch_addr + WORD_STEP);
  endproperty
  a_chain: assert property (p_chain) else $error("chained fetch address wrong");
  property p_dev_write;
    @(posedge mclk) disable iff (!arst_n)
      (state == ST_MEM_REQ && cmd.dir == DIR_WRITE) |=>
        (mem_rd_req && mem_addr == $past(cmd.addr));
  endproperty
  a_dev_write: assert property (p_dev_write) else $error("device write read missing");
  property p_dev_read;
    @(posedge mclk) disable iff (!arst_n)
      (state == ST_MEM_REQ && cmd.dir == DIR_READ && dev_data_valid) |=>
        (mem_wr_req && mem_wdata == $past(ext_in) && mem_addr == $past(cmd.addr));
  endproperty
  a_dev_read: assert property (p_dev_read) else $error("device word not stored");
  property p_to_device;
    @(posedge mclk) disable iff (!arst_n)
      (state == ST_MEM_WAIT && mem_ret_valid) |=>
        (pulse_order[0] && areg_out == $past(mem_ret_data));
  endproperty
  a_to_device: assert property (p_to_device) else $error("word not passed on");
  // a pulse order that stretched would be seen twice by the device
  property p_pulse;
    @(posedge mclk) disable iff (!arst_n) pulse_order[0] |=> !pulse_order[0];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse order too long");
  property p_addr_step;
    @(posedge mclk) disable iff (!arst_n)
      (state == ST_ADVANCE) |=> cmd.addr == $past(cmd.addr) + WORD_STEP;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not advanced");
  property p_refused;
    @(posedge mclk) disable iff (!arst_n) (req_valid && req.op == OP_START && busy) |=>
      (stat_valid && stat_data[31:24] == STAT_BUSY);
  endproperty
  a_refused: assert property (p_refused) else $error("busy not reported");
  property p_dev_sel;
    @(posedge mclk) disable iff (!arst_n) is_start |=> dev_sel == $past(req.dev);
  endproperty
  a_dev_sel: assert property (p_dev_sel) else $error("device not selected");
  property p_dev_hold;
    @(posedge mclk) disable iff (!arst_n) !is_start |=> $stable(dev_sel);
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device selection moved");
  property p_irq_clear;
    @(posedge mclk) disable iff (!arst_n)
      (is_intctl && !req.data[INT_ACTIVE_BIT] && !done_evt) |=> !service_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");
  property p_level_idle;
    @(posedge mclk) disable iff (!arst_n) idle |=> (level_order == 8'h00);
  endproperty
  a_level_idle: assert property (p_level_idle) else $error("level orders left on");
  c_start: cover property (@(posedge mclk) disable iff (!arst_n) is_start ##[1:40] done_evt);
  c_chain: cover property (@(posedge mclk) disable iff (!arst_n)
    (state == ST_ADVANCE && last_item && chain));
  c_write: cover property (@(posedge mclk) disable iff (!arst_n) mem_wr_req);
  c_refused: cover property (@(posedge mclk) disable iff (!arst_n)
    (req_valid && req.op == OP_START && busy));
  c_irq: cover property (@(posedge mclk) disable iff (!arst_n) $rose(service_irq));
endmodule

// ---- sys_mem_model.sv ----
// memory side of the system bus: answers reads after a wait, stores writes
`timescale 1ns/1ps
module sys_mem_model
  import io_seq_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic arst_n, // async reset, active low
  input wire logic slow, // stretch each read answer
  input wire logic mem_rd_req, // read request pulse
  input wire logic mem_wr_req, // write request pulse
  input wire logic [31:0] mem_addr, // byte address
  input wire logic [31:0] mem_wdata, // write data
  output logic mem_ret_valid, // data return pulse
  output logic [31:0] mem_ret_data // return data
);
  logic [31:0] mem [0:15];
  logic pend;
  logic [31:0] pend_addr;
  logic [3:0] wait_left;

  // ==========================================================
  // read answer and write store
  // one read outstanding; idle data lines toggle so a stale word never passes
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ret_valid <= 1'b0;
      mem_ret_data <= 32'h5a5a_a5a5;
      pend <= 1'b0;
      pend_addr <= 32'h0000_0000;
      wait_left <= 4'h0;
    end else begin
      mem_ret_valid <= 1'b0;
      mem_ret_data <= ~mem_ret_data;
      if (mem_wr_req) begin
        mem[mem_addr[5:2]] <= mem_wdata;
      end
      if (mem_rd_req) begin
        pend <= 1'b1;
        pend_addr <= mem_addr;
        wait_left <= slow ? 4'h5 : 4'h0;
      end else if (pend && wait_left == 4'h0) begin
        mem_ret_valid <= 1'b1;
        mem_ret_data <= mem[pend_addr[5:2]];
        pend <= 1'b0;
      end else if (pend) begin
        wait_left <= wait_left - 4'h1;
      end
    end
  end
endmodule

// ---- io_channel_command_sequencer_tb.sv ----
// self-checking testbench for the io channel command sequencer
`timescale 1ns/1ps
module io_channel_command_sequencer_tb
  import io_seq_pkg::*;
;
  logic mclk, arst_n, req_valid, req_ack, in_clear, stat_valid, mem_rd_req, mem_wr_req;
  logic mem_ret_valid, service_irq, dev_data_valid, dev_clk, dev_rst_n, slow, last_pulse;
  bus_req_s req;
  logic [31:0] stat_data, mem_addr, mem_wdata, mem_ret_data, areg_out, breg_out, ext_in;
  logic [7:0] level_order, pulse_order;
  logic [3:0] dev_sel, test_in;
  logic [1:0] cur_dir;
  logic [31:0] rd_q[$], wr_q[$], areg_q[$];
  int fails = 0;
  int n_compared = 0;

  io_channel_command_sequencer io_channel_command_sequencer_i (.mclk(mclk), .arst_n(arst_n),
    .req_valid(req_valid), .req(req), .req_ack(req_ack), .in_clear(in_clear),
    .stat_valid(stat_valid), .stat_data(stat_data), .mem_rd_req(mem_rd_req),
    .mem_wr_req(mem_wr_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ret_valid(mem_ret_valid), .mem_ret_data(mem_ret_data), .service_irq(service_irq),
    .areg_out(areg_out), .breg_out(breg_out), .level_order(level_order),
    .pulse_order(pulse_order), .dev_sel(dev_sel), .ext_in(ext_in),
    .dev_data_valid(dev_data_valid), .test_in(test_in), .dev_clk(dev_clk),
    .dev_rst_n(dev_rst_n));

  sys_mem_model sys_mem_model_i (.mclk(mclk), .arst_n(arst_n), .slow(slow),
    .mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ret_valid(mem_ret_valid), .mem_ret_data(mem_ret_data));

  // ==========================================================
  // checking and reporting
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic cmp_q(input logic [31:0] got[$], input logic [31:0] exp[$], input string msg);
    chk(32'(got.size()), 32'(exp.size()), msg);
    foreach (exp[i]) begin
      if (i < got.size()) begin
        chk(got[i], exp[i], msg);
      end
    end
  endtask

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // bus requests: one-cycle valid, contents left standing afterwards
  task automatic do_req(input logic [3:0] op, input logic [31:0] d, input logic [3:0] dev = 4'h5);
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{op: op, dev: dev, data: d};
    #1;
    chk({31'h0, req_ack}, 32'h1, "acknowledge");
    @(posedge mclk);
    req_valid <= 1'b0;
    #1;
    chk({31'h0, in_clear}, 32'h1, "input clear");
  endtask

  // bounded wait for the traffic to land and the orders to drop
  task automatic wait_idle(input int n_rd, input int n_wr);
    for (int i = 0; i < 2000; i++) begin
      if (rd_q.size() >= n_rd && wr_q.size() >= n_wr && level_order === 8'h00) break;
      @(posedge mclk);
    end
    @(posedge mclk);
    #1;
    chk({24'h0, level_order}, 32'h0, "orders back to idle");
  endtask

  // ==========================================================
  // bus monitor; data items are 32 bits wide, pulse orders one cycle long
  always @(posedge mclk) begin
    if (mem_rd_req === 1'b1) rd_q.push_back(mem_addr);
    if (mem_wr_req === 1'b1) begin
      wr_q.push_back(mem_addr);
      chk(mem_wdata, ext_in, "write data");
      // a fresh device word per item, so a stale sample cannot pass
      ext_in <= ext_in + 32'h0000_0001;
    end
    if (pulse_order[0] === 1'b1) begin
      areg_q.push_back(areg_out);
      chk({31'h0, last_pulse}, 32'h0, "pulse order width");
      chk({24'h0, level_order}, {28'h0, test_in[0], 1'b1, cur_dir}, "level order");
    end
    last_pulse <= pulse_order[0];
  end

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    print_verdict;
  end

  // ==========================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    ext_in = 32'hc0de_0001;
    dev_data_valid = 1'b0;
    test_in = 4'ha;
    slow = 1'b0;
    last_pulse = 1'b0;
    cur_dir = DIR_WRITE;
    for (int i = 0; i < 16; i++) sys_mem_model_i.mem[i] = 32'h0000_0000;
    sys_mem_model_i.mem[4] = 32'h0000_0020;
    sys_mem_model_i.mem[5] = {6'h0, DIR_WRITE, 8'h00, 16'h0002};
    sys_mem_model_i.mem[8] = 32'h1111_0001;
    sys_mem_model_i.mem[9] = 32'h2222_0002;
    sys_mem_model_i.mem[12] = 32'h0000_0040;
    sys_mem_model_i.mem[13] = {6'h0, DIR_READ, 8'h80, 16'h0002};
    sys_mem_model_i.mem[14] = 32'h0000_0050;
    sys_mem_model_i.mem[15] = {6'h0, DIR_READ, 8'h00, 16'h0001};
    #1;
    chk({31'h0, dev_rst_n}, 32'h0, "device reset held");
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk({31'h0, dev_rst_n}, 32'h1, "device reset released");
    chk({31'h0, dev_clk}, {31'h0, mclk}, "device clock");
    chk({24'h0, level_order}, 32'h0, "orders idle");
    do_req(OP_STATUS, 32'h0000_0000);
    chk({31'h0, stat_valid}, 32'h1, "status answer");
    chk(stat_data, {STAT_IDLE, 4'h0, test_in, COUNT_ZERO}, "idle status");
    do_req(OP_INTCTL, 32'h0000_0001);
    chk({31'h0, stat_valid}, 32'h0, "no status for interrupt control");
    // device write of two words, a start refused while busy
    do_req(OP_START, 32'h0000_0010);
    chk({31'h0, mem_rd_req}, 32'h0, "read not yet");
    chk({28'h0, dev_sel}, 32'h0000_0005, "device select");
    @(posedge mclk);
    #1;
    chk({31'h0, mem_rd_req}, 32'h1, "command read");
    chk(mem_addr, 32'h0000_0010, "command address");
    do_req(OP_START, 32'h0000_0070, 4'h9);
    chk({31'h0, stat_valid}, 32'h1, "busy answer");
    chk({24'h0, stat_data[31:24]}, {24'h0, STAT_BUSY}, "busy flag");
    chk({28'h0, dev_sel}, 32'h0000_0005, "device kept while busy");
    wait_idle(4, 0);
    cmp_q(rd_q, '{32'h10, 32'h14, 32'h20, 32'h24}, "read addresses");
    chk(breg_out, 32'h0000_0024, "last data address to device");
    cmp_q(areg_q, '{32'h1111_0001, 32'h2222_0002}, "device data");
    chk({31'h0, service_irq}, 32'h1, "service interrupt");
    do_req(OP_STATUS, 32'h0000_0000);
    chk(stat_data, {STAT_IDLE, 4'h0, test_in, COUNT_ZERO}, "count run out");
    do_req(OP_INTCTL, 32'h0000_0000);
    chk({31'h0, service_irq}, 32'h0, "interrupt cleared");
    // chained device read with slow memory and the level disabled
    rd_q.delete();
    areg_q.delete();
    slow <= 1'b1;
    dev_data_valid <= 1'b1;
    cur_dir = DIR_READ;
    do_req(OP_START, 32'h0000_0030, 4'h6);
    chk({28'h0, dev_sel}, 32'h0000_0006, "second device select");
    wait_idle(4, 3);
    cmp_q(rd_q, '{32'h30, 32'h34, 32'h38, 32'h3c}, "chained fetch");
    cmp_q(wr_q, '{32'h40, 32'h44, 32'h50}, "write addresses");
    chk({31'h0, service_irq}, 32'h0, "level disabled");
    chk(breg_out, 32'h0000_0050, "chained data address");
    chk(sys_mem_model_i.mem[4], 32'hc0de_0003, "stored device word");
    print_verdict;
  end
endmodule
